// >>> include/sfp_pkg.sv
`default_nettype none
package sfp_pkg;
	localparam int DATA_W = 32;
	localparam int NUM_BUF = 4;
	localparam int SEL_W = 5;
	localparam int DEPTH = 16;
	localparam int PTR_W = 4;
	localparam int PART_LEVEL = 12;
	localparam int FLAG_DLY_CYC = 2;
	localparam int SWITCH_DLY_CYC = 4;
	localparam int INT_PORT_DIV = 2;
	localparam logic [2:0] CNT_RST = 3'h0;
	localparam logic [PTR_W:0] LVL_RST = 5'h00;

	typedef enum logic [1:0] {
		SFP_FLAG_EMPTY,
		SFP_FLAG_FULL,
		SFP_FLAG_PARTIAL
	} sfp_flag_kind_type;

	typedef struct packed {
		sfp_flag_kind_type kind;
		logic current;
		logic [1:0] dedicated;
	} sfp_flag_cfg_type;

	typedef struct packed {
		logic selectN;
		logic outEnableN;
		logic readN;
		logic writeN;
		logic commitN;
		logic switchN;
	} sfp_ctl_type;
endpackage
`default_nettype wire

// >>> rtl/sfp_slave_fifo_port.sv
`timescale 1ns/10ps
`default_nettype none
module sfp_slave_fifo_port (
	// clock and reset
	input wire logic core_clk,
	input wire logic rst_n,
	// link pins
	input wire logic ifClk,
	input wire sfp_pkg::sfp_ctl_type ctlPins,
	input wire logic [sfp_pkg::SEL_W-1:0] bufferSelect,
	input wire logic [sfp_pkg::DATA_W-1:0] dataIn,
	output logic [sfp_pkg::DATA_W-1:0] dataOut,
	output logic dataOe,
	output logic [1:0] flagOut,
	output logic threadReady,
	// static configuration and dma side
	input wire logic asyncMode,
	input wire logic wideAddr,
	input wire sfp_pkg::sfp_flag_cfg_type flagCfgA,
	input wire sfp_pkg::sfp_flag_cfg_type flagCfgB,
	input wire logic [sfp_pkg::NUM_BUF-1:0] dmaReady,
	output logic [sfp_pkg::NUM_BUF-1:0] packetCommit,
	output logic [sfp_pkg::NUM_BUF-1:0] zeroLengthCommit
);
	import sfp_pkg::*;

	// ---------------------------------------------
	// pin synchronisers
	// ---------------------------------------------
	logic [6:0] syncA_reg;
	logic [6:0] syncB_reg;
	logic [SEL_W-1:0] selA_reg, selB_reg;
	logic [DATA_W-1:0] datA_reg, datB_reg;
	logic clkPrev_reg, wrPrev_reg;
	// every pin passes two flops before use
	always_ff @(posedge core_clk) begin
		syncA_reg <= {ifClk, ctlPins};
		syncB_reg <= syncA_reg;
		selA_reg <= bufferSelect;
		selB_reg <= selA_reg;
		datA_reg <= dataIn;
		datB_reg <= datA_reg;
		clkPrev_reg <= syncB_reg[6];
		wrPrev_reg <= syncB_reg[2];
	end

	// decoded controls
	wire logic selN = syncB_reg[5];
	wire logic oeN = syncB_reg[4];
	wire logic rdN = syncB_reg[3];
	wire logic wrN = syncB_reg[2];
	wire logic comN = syncB_reg[1];
	wire logic swN = syncB_reg[0];
	wire logic [1:0] curBuf = selB_reg[1:0]; // four buffers
	wire logic active = !selN;

	// ---------------------------------------------
	// sampling edge per mode
	// ---------------------------------------------
	logic [2:0] divCnt_reg;
	wire logic ifRise = syncB_reg[6] && !clkPrev_reg;
	wire logic portTick = (divCnt_reg == 3'(INT_PORT_DIV - 1));
	wire logic tick = asyncMode ? portTick : ifRise;
	wire logic syncRd = !asyncMode && ifRise && active && !rdN;
	wire logic syncWr = !asyncMode && ifRise && active && !wrN;
	wire logic wrRelease = asyncMode && active && wrN && !wrPrev_reg;
	wire logic doWrite = syncWr || wrRelease;
	wire logic doRead = syncRd;
	// zero-length when commit without a write
	wire logic comEvt = (asyncMode ? tick : ifRise) && active && !comN;

	always_ff @(posedge core_clk) begin
		if (!rst_n || divCnt_reg == 3'(INT_PORT_DIV - 1)) begin
			divCnt_reg <= CNT_RST;
		end else begin
			divCnt_reg <= divCnt_reg + 3'h1;
		end
	end

	// ---------------------------------------------
	// buffers and pointers
	// ---------------------------------------------
	logic [DATA_W-1:0] mem [NUM_BUF][DEPTH];
	logic [PTR_W-1:0] wPtr_reg [NUM_BUF];
	logic [PTR_W-1:0] rPtr_reg [NUM_BUF];
	logic [PTR_W:0] level_reg [NUM_BUF];
	logic [PTR_W:0] levelDly_reg [NUM_BUF][FLAG_DLY_CYC];
	logic comDone_reg;
	// moves that really happen: no write to full, no read from empty
	wire logic wrAdv = doWrite && level_reg[curBuf] != (PTR_W+1)'(DEPTH);
	wire logic rdAdv = doRead && level_reg[curBuf] != LVL_RST;

	// storage array, no reset
	always_ff @(posedge core_clk) begin
		if (wrAdv) begin
			mem[curBuf][wPtr_reg[curBuf]] <= datB_reg;
		end
	end

	// pointer and level bookkeeping per buffer
	for (genvar b = 0; b < NUM_BUF; b++) begin : g_buf
		wire logic hit = (curBuf == 2'(b));
		wire logic wrOk = hit && doWrite && level_reg[b] != (PTR_W+1)'(DEPTH);
		wire logic rdOk = hit && doRead && level_reg[b] != LVL_RST;
		always_ff @(posedge core_clk) begin
			if (!rst_n) begin
				wPtr_reg[b] <= '0;
				rPtr_reg[b] <= '0;
				level_reg[b] <= LVL_RST;
				levelDly_reg[b] <= '{default: LVL_RST};
			end else begin
				wPtr_reg[b] <= wPtr_reg[b] + PTR_W'(wrOk);
				rPtr_reg[b] <= rPtr_reg[b] + PTR_W'(rdOk);
				level_reg[b] <= level_reg[b] + (PTR_W+1)'(wrOk) - (PTR_W+1)'(rdOk);
				// flag view lags by fixed delay
				levelDly_reg[b][0] <= level_reg[b];
				for (int k = 1; k < FLAG_DLY_CYC; k++) begin
					levelDly_reg[b][k] <= levelDly_reg[b][k-1];
				end
			end
		end
	end

	// ---------------------------------------------
	// packet commit
	// ---------------------------------------------
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			packetCommit <= '0;
			zeroLengthCommit <= '0;
			comDone_reg <= 1'b0;
		end else begin
			packetCommit <= '0;
			zeroLengthCommit <= '0;
			comDone_reg <= comEvt ? 1'b1 : (comN ? 1'b0 : comDone_reg);
			if (comEvt && !comDone_reg) begin
				if (!wrN || wrRelease) begin
					packetCommit[curBuf] <= 1'b1;
				end else begin
					zeroLengthCommit[curBuf] <= 1'b1;
				end
			end
		end
	end

	// ---------------------------------------------
	// flags
	// ---------------------------------------------
	function automatic logic flagOf(input sfp_flag_cfg_type c, input logic [PTR_W:0] l);
		case (c.kind)
			SFP_FLAG_EMPTY: flagOf = (l == LVL_RST);
			SFP_FLAG_FULL: flagOf = (l == (PTR_W+1)'(DEPTH));
			SFP_FLAG_PARTIAL: flagOf = (l >= (PTR_W+1)'(PART_LEVEL));
			default: flagOf = 1'b0;
		endcase
	endfunction
	wire logic [1:0] bufA = flagCfgA.current ? curBuf : flagCfgA.dedicated;
	wire logic [1:0] bufB = flagCfgB.current ? curBuf : flagCfgB.dedicated;
	wire logic [PTR_W:0] lvlA = levelDly_reg[bufA][FLAG_DLY_CYC-1];
	wire logic [PTR_W:0] lvlB = levelDly_reg[bufB][FLAG_DLY_CYC-1];

	// ---------------------------------------------
	// socket switch
	// ---------------------------------------------
	logic [2:0] swCnt_reg;
	logic swPend_reg;
	wire logic swStart = active && !swN && !swPend_reg && wideAddr;
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			swCnt_reg <= CNT_RST;
			swPend_reg <= 1'b0;
		end else if (swStart) begin
			swCnt_reg <= CNT_RST;
			swPend_reg <= 1'b1;
		end else if (swPend_reg && tick) begin
			swCnt_reg <= swCnt_reg + 3'h1;
			swPend_reg <= (swCnt_reg != 3'(SWITCH_DLY_CYC - 1));
		end
	end

	// ---------------------------------------------
	// outputs
	// ---------------------------------------------
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			dataOut <= '0;
			dataOe <= 1'b0;
			flagOut <= '0;
			threadReady <= 1'b0;
		end else begin
			dataOe <= active && !oeN;
			// previously addressed word, then next after edge
			dataOut <= (active && !oeN) ? mem[curBuf][rPtr_reg[curBuf] + PTR_W'(rdAdv)] : '0;
			flagOut <= {flagOf(flagCfgB, lvlB), flagOf(flagCfgA, lvlA)};
			threadReady <= !swPend_reg && !swStart && dmaReady[curBuf];
		end
	end

	// ---------------------------------------------
	// checks
	// ---------------------------------------------
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	a_bus_oe_only: assert property (dataOe |-> $past(active && !oeN))
		else $error("bus driven without enable");
	a_deselect_float: assert property (selN |=> !dataOe)
		else $error("bus driven while deselected");
	a_read_advance: assert property (
		rdAdv |=> rPtr_reg[$past(curBuf)] == $past(rPtr_reg[curBuf]) + 4'h1)
		else $error("read pointer did not advance");
	a_write_advance: assert property (
		wrAdv |=> wPtr_reg[$past(curBuf)] == $past(wPtr_reg[curBuf]) + 4'h1)
		else $error("write pointer did not advance");
	a_flag_delay: assert property (##2 levelDly_reg[0][1] == $past(level_reg[0], 2))
		else $error("flag delay wrong");
	a_zlp_commit: assert property (
		comEvt && !comDone_reg && wrN && !wrRelease |=> zeroLengthCommit[$past(curBuf)])
		else $error("zero length packet missed");
	a_no_switch_narrow: assert property (!wideAddr |-> !swStart)
		else $error("switch delay in narrow mode");
	a_switch_ready: assert property (swStart |=> !threadReady)
		else $error("ready during switch");
	a_async_capture: assert property (asyncMode && !wrN && active |=> !($past(doWrite)))
		else $error("async write before release");
	c_burst_read: cover property (syncRd ##8 syncRd);
	c_burst_write: cover property (syncWr ##8 syncWr);
	c_short_pkt: cover property (packetCommit != '0);
	c_switch: cover property (swStart ##[1:60] threadReady);
endmodule // sfp_slave_fifo_port
`default_nettype wire

// >>> dv/sfp_master_model.sv
`timescale 1ns/10ps
`default_nettype none
module sfp_master_model (
	// link pins
	output logic ifClk,
	output var sfp_pkg::sfp_ctl_type ctlPins,
	output logic [sfp_pkg::SEL_W-1:0] bufferSelect,
	output logic [sfp_pkg::DATA_W-1:0] dataIn
);
	import sfp_pkg::*;
	// idle: clock still, strobes high
	initial begin
		ifClk = 1'h0;
		ctlPins = 6'h3F;
		bufferSelect = 5'h00;
		dataIn = 32'h00000000;
	end
	// one link period, pins move while low
	task automatic tick();
		#7 ifClk = 1'h1;
		#200 ifClk = 1'h0;
		#193;
	endtask
	// address first, then select
	task automatic open_port(input logic [SEL_W-1:0] b);
		bufferSelect = b;
		#20 ctlPins.selectN = 1'h0;
	endtask
	// release all; released bus shows the inverse
	task automatic close_port();
		ctlPins = 6'h3F;
		dataIn = ~dataIn;
		#400;
	endtask
	// burst write, commit with the last word
	task automatic sync_write(input logic [SEL_W-1:0] b, input int n,
		input logic [DATA_W-1:0] w, input logic cm);
		open_port(b);
		for (int i = 0; i < n; i++) begin
			dataIn = w + DATA_W'(i);
			ctlPins.writeN = 1'h0;
			ctlPins.commitN = !(cm && i == n - 1);
			tick();
		end
		close_port();
	endtask
	// strobe-edge write, data set up before release
	task automatic async_write(input logic [SEL_W-1:0] b, input logic [DATA_W-1:0] w,
		input logic cm);
		open_port(b);
		dataIn = w;
		ctlPins.writeN = 1'h0;
		ctlPins.commitN = !cm;
		#300 ctlPins.writeN = 1'h1;
		#100;
		close_port();
	endtask
	// raw pin pattern for one edge
	task automatic drive_tick(input logic [SEL_W-1:0] b, input sfp_ctl_type p);
		bufferSelect = b;
		ctlPins = p;
		tick();
	endtask
	// select, then enable the bus
	task automatic read_setup(input logic [SEL_W-1:0] b);
		open_port(b);
		#100 ctlPins.outEnableN = 1'h0;
		#400;
	endtask
	task automatic read_step();
		ctlPins.readN = 1'h0;
		tick();
	endtask
	// switch strobe with new address
	task automatic switch_to(input logic [SEL_W-1:0] b);
		bufferSelect = b;
		ctlPins.selectN = 1'h0;
		ctlPins.switchN = 1'h0;
		tick();
		ctlPins.switchN = 1'h1;
	endtask
endmodule // sfp_master_model
`default_nettype wire

// >>> dv/sfp_slave_fifo_port_test.sv
`timescale 1ns/10ps
`default_nettype none
module sfp_slave_fifo_port_test;
	import sfp_pkg::*;
	logic core_clk, rst_n, ifClk, dataOe, threadReady, asyncMode, wideAddr, clrSeen;
	sfp_ctl_type ctlPins;
	logic [SEL_W-1:0] bufferSelect;
	logic [DATA_W-1:0] dataIn, dataOut;
	logic [1:0] flagOut;
	logic [NUM_BUF-1:0] dmaReady, packetCommit, zeroLengthCommit, pcSeen, zlSeen;
	sfp_flag_cfg_type flagCfgA, flagCfgB;
	int failures, checked;
	int cycles = 0;
	sfp_master_model mst (.ifClk(ifClk), .ctlPins(ctlPins), .bufferSelect(bufferSelect),
		.dataIn(dataIn));
	sfp_slave_fifo_port DUT (.core_clk(core_clk), .rst_n(rst_n), .ifClk(ifClk),
		.ctlPins(ctlPins), .bufferSelect(bufferSelect), .dataIn(dataIn), .dataOut(dataOut),
		.dataOe(dataOe), .flagOut(flagOut), .threadReady(threadReady), .asyncMode(asyncMode),
		.wideAddr(wideAddr), .flagCfgA(flagCfgA), .flagCfgB(flagCfgB), .dmaReady(dmaReady),
		.packetCommit(packetCommit), .zeroLengthCommit(zeroLengthCommit));
	// clock
	initial begin
		core_clk = 1'h0;
		forever #25 core_clk = ~core_clk;
	end
	// sticky commit pulses and cycle ceiling
	always @(posedge core_clk) begin
		pcSeen <= clrSeen ? 4'h0 : (pcSeen | packetCommit);
		zlSeen <= clrSeen ? 4'h0 : (zlSeen | zeroLengthCommit);
		cycles <= cycles + 1;
		if (cycles == 5000) begin
			failures++;
			finish_test();
		end
	end
	task automatic finish_test();
		$display("checked %0d failures %0d", checked, failures);
		if (failures == 0 && checked > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task automatic check(input string what, input logic [DATA_W-1:0] seen,
		input logic [DATA_W-1:0] exp);
		checked++;
		if (seen !== exp) begin
			failures++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask
	// wipe the sticky commit records
	task automatic clear_seen();
		@(negedge core_clk) clrSeen = 1'h1;
		@(negedge core_clk) clrSeen = 1'h0;
	endtask
	// burst read of n words from w upward
	task automatic read_burst(input logic [SEL_W-1:0] b, input int n, input logic [DATA_W-1:0] w);
		mst.read_setup(b);
		check("enable", dataOe, 1'h1);
		for (int i = 0; i < n; i++) begin
			check("word", dataOut, w + DATA_W'(i));
			mst.read_step();
		end
		mst.close_port();
		check("release", dataOe, 1'h0);
	endtask
	task automatic t_write_read();
		clear_seen();
		mst.sync_write(5'h00, 4, 32'hA5000000, 1'h1);
		check("commit", pcSeen, 4'h1);
		check("empty", flagOut[0], 1'h0);
		read_burst(5'h00, 4, 32'hA5000000);
		check("empty", flagOut[0], 1'h1);
	endtask
	// seventeenth word refused on a full buffer
	task automatic t_full();
		clear_seen();
		mst.sync_write(5'h02, 17, 32'h3C000010, 1'h0);
		check("full", flagOut[1], 1'h1);
		check("commit", pcSeen, 4'h0);
		@(negedge core_clk) flagCfgA = '{SFP_FLAG_PARTIAL, 1'h1, 2'h0};
		#400 check("partial", flagOut[0], 1'h1);
		read_burst(5'h02, 16, 32'h3C000010);
		check("full", flagOut[1], 1'h0);
		check("partial", flagOut[0], 1'h0);
		@(negedge core_clk) flagCfgA = '{SFP_FLAG_EMPTY, 1'h0, 2'h0};
	endtask
	task automatic t_async();
		clear_seen();
		@(negedge core_clk) asyncMode = 1'h1;
		mst.async_write(5'h01, 32'h5AF00F00, 1'h0);
		mst.async_write(5'h01, 32'h5AF00F01, 1'h1);
		check("commit", pcSeen, 4'h2);
		@(negedge core_clk) asyncMode = 1'h0;
		read_burst(5'h01, 2, 32'h5AF00F00);
	endtask
	task automatic t_zero();
		clear_seen();
		mst.drive_tick(5'h03, 6'h20);
		check("floating", dataOe, 1'h0);
		mst.close_port();
		check("ignored", zlSeen, 4'h0);
		mst.drive_tick(5'h03, 6'h1D);
		mst.close_port();
		check("zero", zlSeen, 4'h8);
		check("short", pcSeen, 4'h0);
	endtask
	task automatic t_switch();
		@(negedge core_clk) wideAddr = 1'h1;
		mst.switch_to(5'h01);
		check("pending", threadReady, 1'h0);
		repeat (2) mst.tick();
		check("counting", threadReady, 1'h0);
		repeat (3) mst.tick();
		check("ready", threadReady, 1'h1);
		@(negedge core_clk) dmaReady = 4'hD;
		#400 check("notready", threadReady, 1'h0);
		@(negedge core_clk) wideAddr = 1'h0;
		mst.switch_to(5'h02);
		check("nodelay", threadReady, 1'h1);
	endtask
	initial begin
		rst_n = 1'h0;
		asyncMode = 1'h0;
		wideAddr = 1'h0;
		dmaReady = 4'hF;
		flagCfgA = '{SFP_FLAG_EMPTY, 1'h0, 2'h0};
		flagCfgB = '{SFP_FLAG_FULL, 1'h0, 2'h2};
		failures = 0;
		checked = 0;
		clrSeen = 1'h1;
		repeat (8) @(posedge core_clk);
		@(negedge core_clk) rst_n = 1'h1;
		clrSeen = 1'h0;
		repeat (4) @(negedge core_clk);
		t_write_read();
		t_full();
		t_async();
		t_zero();
		t_switch();
		finish_test();
	end
endmodule // sfp_slave_fifo_port_test
`default_nettype wire
